// file: dpp_pkg.sv
package dpp_pkg;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 4;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_A_DATA = 4'h0;
  localparam logic [3:0] OFS_A_DIR = 4'h1;
  localparam logic [3:0] OFS_A_ANSEL = 4'h2;
  localparam logic [3:0] OFS_B_DATA = 4'h3;
  localparam logic [3:0] OFS_B_DIR = 4'h4;
  localparam logic [3:0] OFS_B_ANSEL = 4'h5;
  localparam logic [3:0] OFS_B_PULLUP = 4'h6;
  localparam logic [3:0] OFS_OPTION = 4'h7;
  localparam logic [3:0] OFS_ALT_PIN = 4'h8;
  localparam logic [3:0] OFS_ADC_CTRL = 4'h9;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int OPT_PULLUP_DIS_BIT = 7;
  localparam int ALT_SS_ROUTE_BIT = 1;
  localparam int ALT_CCP2_BIT = 0;
  localparam int A_T0CK_BIT = 4;
  localparam int A_SS_HI_BIT = 5;
  localparam int A_SS_LO_BIT = 0;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_ANSEL = 8'h3f;
  localparam logic [7:0] ANSEL_MASK = 8'h3f;
  localparam logic [7:0] RST_PULLUP = 8'hff;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_ALT_PIN = 8'h00;
  localparam logic [7:0] ALT_MASK = 8'h03;
  localparam logic [7:0] RST_ADC_CTRL = 8'h00;
  localparam logic [7:0] ADC_MASK = 8'h3f;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam int SYNC_STAGES = 2;
endpackage

// file: dpp_sync.sv
`timescale 1ns/1ps
module dpp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  // ----------------------------------------------------------------
  // two-flop synchroniser, first stage read only by second
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("synchroniser width must be at least one");
  end
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// file: dpp_top.sv
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// R01 - second-port direction one tristates pin, zero drives the latch
// R02 - second port is eight bits, one direction and data bit each
// R03 - data read returns pin levels, write goes to output latch
// R04 - port writes read pins, modify, store whole byte to latch
// R05 - direction bits drive outputs even on analog-selected pins
// R06 - software keeps direction set to input on analog pins
// R07 - analog-selected pin always reads zero digitally
// R08 - analog select never affects digital output driving
// R09 - each second-port pin has weak pull-up with own enable bit
// R10 - pull-up switched off when pin is an output
// R11 - after reset global pull-up disable bit turns all pull-ups off
// R12 - individual pull-ups act only while global disable is clear
// R13 - timer0 clock input samples first-port bit 4 always
// R14 - bit 4 as output drives pad and clocks timer0 at once
// R15 - slave-select input routes to first-port bit 5 or bit 0
// R16 - alternate-pin bit 1 zero picks bit 5, one picks bit 0
// R17 - first-port bit 4 serves as gpio, sensing or timer0 clock
// R18 - pin levels pass a two-flop synchroniser before read path
module dpp_top #(
  parameter int PORT_WIDTH = 8
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic [7:0] I_PA_IN,
  output logic [7:0] O_PA_OUT,
  output logic [7:0] O_PA_OE,
  input wire logic [7:0] I_PB_IN,
  output logic [7:0] O_PB_OUT,
  output logic [7:0] O_PB_OE,
  output logic [7:0] O_PB_PULLUP,
  output logic [7:0] O_PA_ANALOG,
  output logic [7:0] O_PB_ANALOG,
  output logic O_TIMER0_EXT_CLOCK_IN,
  output logic O_SLAVE_SELECT_IN,
  output logic [7:0] O_OPTION,
  output logic [7:0] O_ADC_CTRL,
  output logic O_CCP2_ROUTE
);
  // the pad vectors are fixed at eight bits, so refuse any other width
  if (PORT_WIDTH != dpp_pkg::PORT_W) begin : g_bad_width
    $error("port width must be eight");
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] a_latch_reg;
  logic [7:0] a_dir_reg;
  logic [7:0] a_ansel_reg;
  logic [7:0] b_latch_reg;
  logic [7:0] b_dir_reg;
  logic [7:0] b_ansel_reg;
  logic [7:0] b_pullup_reg;
  logic [7:0] option_reg;
  logic [7:0] alt_pin_reg;
  logic [7:0] adc_ctrl_reg;
  logic [7:0] rdata_next;
  logic [7:0] pa_sync;
  logic [7:0] pb_sync;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dpp_sync #(.WIDTH(8)) u_sync_a ( // [R18]
    .i_clk(I_CORE_CLK),
    .i_resetn(I_RESETN),
    .i_async(I_PA_IN),
    .o_sync(pa_sync)
  );
  dpp_sync #(.WIDTH(8)) u_sync_b ( // [R18]
    .i_clk(I_CORE_CLK),
    .i_resetn(I_RESETN),
    .i_async(I_PB_IN),
    .o_sync(pb_sync)
  );

  // ----------------------------------------------------------------
  // digital read path
  // ----------------------------------------------------------------
  function automatic logic [7:0] dig_read(input logic [7:0] pins,
                                          input logic [7:0] ansel);
    dig_read = pins & ~ansel; // [R07]
  endfunction

  wire [7:0] a_read = dig_read(pa_sync, a_ansel_reg); // [R03]
  wire [7:0] b_read = dig_read(pb_sync, b_ansel_reg); // [R03]

  // the cpu presents a full byte, so the modify step replaces every bit;
  // analog pins read zero, which is why rmw on mixed ports surprises users
  wire [7:0] a_rmw = (a_read & 8'h00) | I_WDATA; // [R04]
  wire [7:0] b_rmw = (b_read & 8'h00) | I_WDATA; // [R04]

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire wr_a_data = I_WR && (I_ADDR == dpp_pkg::OFS_A_DATA);
  wire wr_a_dir = I_WR && (I_ADDR == dpp_pkg::OFS_A_DIR);
  wire wr_a_ansel = I_WR && (I_ADDR == dpp_pkg::OFS_A_ANSEL);
  wire wr_b_data = I_WR && (I_ADDR == dpp_pkg::OFS_B_DATA);
  wire wr_b_dir = I_WR && (I_ADDR == dpp_pkg::OFS_B_DIR);
  wire wr_b_ansel = I_WR && (I_ADDR == dpp_pkg::OFS_B_ANSEL);
  wire wr_b_pullup = I_WR && (I_ADDR == dpp_pkg::OFS_B_PULLUP);
  wire wr_option = I_WR && (I_ADDR == dpp_pkg::OFS_OPTION);
  wire wr_alt = I_WR && (I_ADDR == dpp_pkg::OFS_ALT_PIN);
  wire wr_adc = I_WR && (I_ADDR == dpp_pkg::OFS_ADC_CTRL);

  always_comb begin
    rdata_next = 8'h00;
    case (I_ADDR)
      dpp_pkg::OFS_A_DATA: rdata_next = a_read; // [R03]
      dpp_pkg::OFS_A_DIR: rdata_next = a_dir_reg;
      dpp_pkg::OFS_A_ANSEL: rdata_next = a_ansel_reg;
      dpp_pkg::OFS_B_DATA: rdata_next = b_read; // [R03]
      dpp_pkg::OFS_B_DIR: rdata_next = b_dir_reg;
      dpp_pkg::OFS_B_ANSEL: rdata_next = b_ansel_reg;
      dpp_pkg::OFS_B_PULLUP: rdata_next = b_pullup_reg;
      dpp_pkg::OFS_OPTION: rdata_next = option_reg;
      dpp_pkg::OFS_ALT_PIN: rdata_next = alt_pin_reg;
      dpp_pkg::OFS_ADC_CTRL: rdata_next = adc_ctrl_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // reserved bits are masked on the way in so they always read zero
  wire [7:0] a_latch_next = wr_a_data ? a_rmw : a_latch_reg; // [R04]
  wire [7:0] a_dir_next = wr_a_dir ? I_WDATA : a_dir_reg;
  wire [7:0] a_ansel_next = wr_a_ansel ?
    (I_WDATA & dpp_pkg::ANSEL_MASK) : a_ansel_reg;
  wire [7:0] b_latch_next = wr_b_data ? b_rmw : b_latch_reg; // [R04]
  wire [7:0] b_dir_next = wr_b_dir ? I_WDATA : b_dir_reg; // [R02]
  wire [7:0] b_ansel_next = wr_b_ansel ?
    (I_WDATA & dpp_pkg::ANSEL_MASK) : b_ansel_reg;
  wire [7:0] b_pullup_next = wr_b_pullup ? I_WDATA : b_pullup_reg; // [R09]
  wire [7:0] option_next = wr_option ? I_WDATA : option_reg;
  wire [7:0] alt_pin_next = wr_alt ?
    (I_WDATA & dpp_pkg::ALT_MASK) : alt_pin_reg;
  wire [7:0] adc_ctrl_next = wr_adc ?
    (I_WDATA & dpp_pkg::ADC_MASK) : adc_ctrl_reg;

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      a_latch_reg <= dpp_pkg::RST_LATCH;
    end else begin
      a_latch_reg <= a_latch_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      a_dir_reg <= dpp_pkg::RST_DIR;
    end else begin
      a_dir_reg <= a_dir_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      a_ansel_reg <= dpp_pkg::RST_ANSEL;
    end else begin
      a_ansel_reg <= a_ansel_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      b_latch_reg <= dpp_pkg::RST_LATCH;
    end else begin
      b_latch_reg <= b_latch_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      b_dir_reg <= dpp_pkg::RST_DIR;
    end else begin
      b_dir_reg <= b_dir_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      b_ansel_reg <= dpp_pkg::RST_ANSEL;
    end else begin
      b_ansel_reg <= b_ansel_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      b_pullup_reg <= dpp_pkg::RST_PULLUP;
    end else begin
      b_pullup_reg <= b_pullup_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      option_reg <= dpp_pkg::RST_OPTION; // [R11]
    end else begin
      option_reg <= option_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      alt_pin_reg <= dpp_pkg::RST_ALT_PIN;
    end else begin
      alt_pin_reg <= alt_pin_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      adc_ctrl_reg <= dpp_pkg::RST_ADC_CTRL;
    end else begin
      adc_ctrl_reg <= adc_ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // pin drive, pull-ups and peripheral inputs
  // ----------------------------------------------------------------
  // drivers ignore analog select entirely; software is expected to keep
  // analog pins as inputs, the logic does not enforce it
  wire [7:0] pa_oe_next = ~a_dir_reg; // [R05] [R08]
  wire [7:0] pb_oe_next = ~b_dir_reg; // [R01] [R05] [R08]
  wire pullup_global_on = !option_reg[dpp_pkg::OPT_PULLUP_DIS_BIT]; // [R12]
  wire [7:0] pullup_next;
  // per pin: own enable, pin still an input, global gate open
  for (genvar p = 0; p < PORT_WIDTH; p++) begin : g_pullup
    assign pullup_next[p] = pullup_global_on && b_pullup_reg[p] &&
      b_dir_reg[p]; // [R09] [R10] [R12]
  end

  // timer0 taps the pad level whatever the direction, so an output latch
  // value clocks it too; this costs two cycles of synchroniser latency
  wire t0_next = pa_sync[dpp_pkg::A_T0CK_BIT]; // [R13] [R14] [R17]
  wire ss_next = alt_pin_reg[dpp_pkg::ALT_SS_ROUTE_BIT] ?
    pa_sync[dpp_pkg::A_SS_LO_BIT] :
    pa_sync[dpp_pkg::A_SS_HI_BIT]; // [R15] [R16]

  // read data stand in each cycle after one with I_RD high and are zero otherwise
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= I_RD ? rdata_next : 8'h00;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PA_OUT <= dpp_pkg::RST_LATCH;
    end else begin
      O_PA_OUT <= a_latch_reg; // [R14]
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PA_OE <= 8'h00;
    end else begin
      O_PA_OE <= pa_oe_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PB_OUT <= dpp_pkg::RST_LATCH;
    end else begin
      O_PB_OUT <= b_latch_reg; // [R01]
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PB_OE <= 8'h00;
    end else begin
      O_PB_OE <= pb_oe_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PB_PULLUP <= 8'h00;
    end else begin
      O_PB_PULLUP <= pullup_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PA_ANALOG <= dpp_pkg::RST_ANSEL;
    end else begin
      O_PA_ANALOG <= a_ansel_reg;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_PB_ANALOG <= dpp_pkg::RST_ANSEL;
    end else begin
      O_PB_ANALOG <= b_ansel_reg;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_TIMER0_EXT_CLOCK_IN <= 1'b0;
    end else begin
      O_TIMER0_EXT_CLOCK_IN <= t0_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SLAVE_SELECT_IN <= 1'b0;
    end else begin
      O_SLAVE_SELECT_IN <= ss_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_OPTION <= dpp_pkg::RST_OPTION;
    end else begin
      O_OPTION <= option_reg;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_ADC_CTRL <= dpp_pkg::RST_ADC_CTRL;
    end else begin
      O_ADC_CTRL <= adc_ctrl_reg;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_CCP2_ROUTE <= 1'b0;
    end else begin
      O_CCP2_ROUTE <= alt_pin_reg[dpp_pkg::ALT_CCP2_BIT];
    end
  end
endmodule

// file: dpp_board.sv
`timescale 1ns/1ps
// pads seen from the board; an undriven pin without pull-up toggles so
// that a stale value can never pass for a real level
module dpp_board (
  input wire logic i_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pullup,
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_pad
);
  logic [7:0] float_reg = 8'h55;
  always_ff @(posedge i_clk) begin
    float_reg <= ~float_reg;
  end
  assign o_pad = (i_oe & i_out)
    | (~i_oe & i_ext_en & i_ext_val)
    | (~i_oe & ~i_ext_en & i_pullup)
    | (~i_oe & ~i_ext_en & ~i_pullup & float_reg);
endmodule

// file: dpp_checker.sv
`timescale 1ns/1ps
module dpp_checker (
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic [7:0] I_PA_IN,
  input wire logic [7:0] O_PB_OUT,
  input wire logic [7:0] O_PB_OE,
  input wire logic [7:0] O_PB_PULLUP,
  input wire logic [7:0] O_PB_ANALOG,
  input wire logic O_TIMER0_EXT_CLOCK_IN,
  input wire logic [7:0] O_OPTION,
  input wire logic O_CCP2_ROUTE
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_wr_dir; I_WR && I_ADDR == dpp_pkg::OFS_B_DIR; endsequence
  sequence s_wr_dat; I_WR && I_ADDR == dpp_pkg::OFS_B_DATA; endsequence
  // past reset check keeps the empty synchroniser out of the antecedent
  sequence s_t0_steady;
    $stable(I_PA_IN[4]) [*4] ##0 $past(I_RESETN, 5);
  endsequence
  property p_oe_dir; s_wr_dir |-> ##2 O_PB_OE == ~$past(I_WDATA, 2);
  endproperty
  property p_latch; s_wr_dat |-> ##2 O_PB_OUT == $past(I_WDATA, 2);
  endproperty
  property p_pull_out; (O_PB_PULLUP & O_PB_OE) == 8'h00; endproperty
  property p_pull_glob; O_OPTION[7] |-> O_PB_PULLUP == 8'h00; endproperty
  property p_ansel_zero; I_RD && I_ADDR == dpp_pkg::OFS_B_DATA
    |=> (O_RDATA & O_PB_ANALOG) == 8'h00; endproperty
  property p_rd_idle; !I_RD |=> O_RDATA == 8'h00; endproperty
  property p_unmapped; I_RD && I_ADDR > 4'h9 |=> O_RDATA == 8'h00;
  endproperty
  property p_timer; s_t0_steady |-> O_TIMER0_EXT_CLOCK_IN == I_PA_IN[4];
  endproperty
  property p_ccp2; I_WR && I_ADDR == dpp_pkg::OFS_ALT_PIN
    |-> ##2 O_CCP2_ROUTE == $past(I_WDATA[0], 2); endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("oe off");
  a_latch: assert property (p_latch) else $error("latch off");
  a_pull_out: assert property (p_pull_out) else $error("pu on out");
  a_pull_glob: assert property (p_pull_glob) else $error("pu on");
  a_ansel_zero: assert property (p_ansel_zero) else $error("an");
  a_rd_idle: assert property (p_rd_idle) else $error("rdata held");
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  a_timer: assert property (p_timer) else $error("timer0 in");
  a_ccp2: assert property (p_ccp2) else $error("ccp2 route");
endmodule
bind dpp_top dpp_checker dpp_checker_i (.I_CORE_CLK(I_CORE_CLK),
  .I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PA_IN(I_PA_IN), .O_PB_OUT(O_PB_OUT),
  .O_PB_OE(O_PB_OE), .O_PB_PULLUP(O_PB_PULLUP), .O_PB_ANALOG(O_PB_ANALOG),
  .O_TIMER0_EXT_CLOCK_IN(O_TIMER0_EXT_CLOCK_IN), .O_OPTION(O_OPTION),
  .O_CCP2_ROUTE(O_CCP2_ROUTE));

// file: test_dual_port_pin_control.sv
`timescale 1ns/1ps
module test_dual_port_pin_control;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, tmr, ss;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, ea_v = 8'h00, ea_e = 8'h00;
  logic [7:0] eb_v = 8'h00, eb_e = 8'h00;
  logic [7:0] pa, pb, pa_out, pa_oe, pb_out, pb_oe, pb_pu, rdata;
  logic [7:0] pa_an, adc;
  int n_fail = 0, checked = 0;
  dpp_top dpp_top_i (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PA_IN(pa),
    .O_PA_OUT(pa_out), .O_PA_OE(pa_oe), .I_PB_IN(pb), .O_PB_OUT(pb_out),
    .O_PB_OE(pb_oe), .O_PB_PULLUP(pb_pu), .O_PA_ANALOG(pa_an), .O_PB_ANALOG(),
    .O_TIMER0_EXT_CLOCK_IN(tmr), .O_SLAVE_SELECT_IN(ss), .O_OPTION(),
    .O_ADC_CTRL(adc), .O_CCP2_ROUTE());
  dpp_board board_a (.i_clk(clk), .i_out(pa_out), .i_oe(pa_oe),
    .i_pullup(8'h00), .i_ext_val(ea_v), .i_ext_en(ea_e), .o_pad(pa));
  dpp_board board_b (.i_clk(clk), .i_out(pb_out), .i_oe(pb_oe),
    .i_pullup(pb_pu), .i_ext_val(eb_v), .i_ext_en(eb_e), .o_pad(pb));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rdc(logic [3:0] a, logic [7:0] e);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 check($sformatf("reg %h", a), rdata, e);
  endtask
  // pads need two sync edges, timer and slave-select one more
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000 n_fail++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 check("pb_pullup", pb_pu, 8'h00);
    check("pb_oe", pb_oe, 8'h00);
    check("pa_analog", pa_an, 8'h3f);
    rdc(dpp_pkg::OFS_B_DIR, 8'hff);
    rdc(dpp_pkg::OFS_A_DIR, 8'hff);
    rdc(dpp_pkg::OFS_B_ANSEL, 8'h3f);
    rdc(dpp_pkg::OFS_B_PULLUP, 8'hff);
    rdc(dpp_pkg::OFS_OPTION, 8'hff);
    rdc(dpp_pkg::OFS_ALT_PIN, 8'h00);
    wr_reg(dpp_pkg::OFS_ALT_PIN, 8'hff);
    rdc(dpp_pkg::OFS_ALT_PIN, 8'h03);
    wr_reg(dpp_pkg::OFS_ADC_CTRL, 8'hff);
    rdc(dpp_pkg::OFS_ADC_CTRL, 8'h3f);
    check("adc_ctrl", adc, 8'h3f);
    wr_reg(4'hc, 8'hff);
    rdc(4'hc, 8'h00);
    wr_reg(dpp_pkg::OFS_B_ANSEL, 8'h00);
    wr_reg(dpp_pkg::OFS_B_DATA, 8'ha5);
    wr_reg(dpp_pkg::OFS_B_DIR, 8'h0f);
    eb_v <= 8'h06;
    eb_e <= 8'h0f;
    settle();
    check("pb_oe", pb_oe, 8'hf0);
    check("pb_out", pb_out, 8'ha5);
    rdc(dpp_pkg::OFS_B_DATA, 8'ha6);
    wr_reg(dpp_pkg::OFS_B_DATA, 8'hc3);
    settle();
    check("pb_out", pb_out, 8'hc3);
    rdc(dpp_pkg::OFS_B_DATA, 8'hc6);
    wr_reg(dpp_pkg::OFS_OPTION, 8'h7f);
    settle();
    check("pb_pullup", pb_pu, 8'h0f);
    wr_reg(dpp_pkg::OFS_B_PULLUP, 8'h05);
    settle();
    check("pb_pullup", pb_pu, 8'h05);
    wr_reg(dpp_pkg::OFS_OPTION, 8'hff);
    settle();
    check("pb_pullup", pb_pu, 8'h00);
    wr_reg(dpp_pkg::OFS_B_ANSEL, 8'h3f);
    settle();
    rdc(dpp_pkg::OFS_B_DATA, 8'hc0);
    check("pb_out", pb_out, 8'hc3);
    check("pb_oe", pb_oe, 8'hf0);
    ea_v <= 8'h20;
    ea_e <= 8'hff;
    wr_reg(dpp_pkg::OFS_A_ANSEL, 8'h00);
    wr_reg(dpp_pkg::OFS_A_DATA, 8'h10);
    wr_reg(dpp_pkg::OFS_A_DIR, 8'hef);
    settle();
    check("timer0", {7'h00, tmr}, 8'h01);
    check("pa_out", pa_out, 8'h10);
    check("pa_oe", pa_oe, 8'h10);
    check("pa_analog", pa_an, 8'h00);
    rdc(dpp_pkg::OFS_A_DATA, 8'h30);
    check("ss", {7'h00, ss}, 8'h00);
    wr_reg(dpp_pkg::OFS_A_DIR, 8'hff);
    wr_reg(dpp_pkg::OFS_ALT_PIN, 8'h00);
    settle();
    check("timer0", {7'h00, tmr}, 8'h00);
    check("ss", {7'h00, ss}, 8'h01);
    end_of_test();
  end
endmodule
